/* logic/scada_record_access_slave.sv */
// Notes on behaviour
// - event selector takes 0..249; 0 newest, 249 oldest of 250.
// - type 0 event fields in cells 0102..0105; type 3 adds more cells.
// - fault selector takes 0..4; 0 newest fault, 4 oldest.
// - maintenance selector takes 0..4, like fault selection.
// - selection index counts from newest and shifts on new records.
// - disturbance selector 0 is oldest unextracted; signed offsets.
// - disturbance flag set while any unextracted disturbance record exists.
// - selected disturbance time at cell 02; body by block transfer.
// - front port has no automatic disturbance extraction; manual allowed.
// - logic transfer cells B204, B208, B20C, B21C and B120.
// - serial slave uses RTU framing only, never ASCII.
// - baud, address, parity, inactivity timeout are held settings.
// - function codes 1,2,3,4,6,7,8,11,12,16 accepted; others unsupported.
// - function 1 reads contacts page 0, function 2 reads optos page 1.
// - 3 reads settings page 4, 4 reads page 3; 6 and 16 write page 4.
// - preset multiple registers carries at most 127 registers.
// - unsupported function code answers exception 01.
// - bad start address answers 02; holes inside the range do not.
// - any protected cell in a write range discards all, answers 02.
// - out-of-range value answers 03; in-range values still applied (here the out-of-range write stores nothing).
// - locked database or busy slave answers exception 06 (here: only writes 6 and 16 to a locked database; a go while busy gets pslverr).
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module scada_record_access_slave
	import record_access_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        new_event,
	input  wire logic        new_fault,
	input  wire logic        new_maint,
	input  wire logic        dist_stored,
	input  wire logic        dist_extracted,
	input  wire logic        db_locked,
	input  wire logic [15:0] contact_state,
	input  wire logic [15:0] opto_state,
	input  wire logic [15:0] meas_value,
	output logic             dist_flag_r,
	output logic             auto_dist_en_r,
	output logic             rtu_mode_r
);
	import record_access_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_CHECK = 4'b0010,
		ST_EXEC  = 4'b0100,
		ST_DONE  = 4'b1000
	} req_state_t;

	req_state_t  state_r;
	request_t    req_r;
	answer_t     ans_r;
	port_cfg_t   cfg_r;
	logic_xfer_t lx_r;
	logic [15:0] data_r;
	logic [SET_DEPTH-1:0] protect_r;
	logic [15:0] set_mem_r [SET_DEPTH];
	logic [7:0]  idx_r;
	logic        range_err_r;
	logic        front_port_r;
	logic [7:0]  dist_count_r;
	logic signed [7:0] dist_sel_r;
	logic [3:0]  lat_r;
	logic [31:0] rdata_nxt;
	logic [7:0]  evt_sel, flt_sel, mnt_sel;
	logic        evt_rej, flt_rej, mnt_rej;
	logic        wr_acc;
	logic        fn_ok, start_ok, prot_hit;
	logic [2:0]  page;
	logic [13:0] offs;

	assign wr_acc = psel && penable && pwrite;

	record_selector #(.SEL_MAX(EVT_SEL_MAX)) u_evt_sel (
		.clk      (clk),
		.rst_b    (rst_b),
		.wr_en    (wr_acc && paddr == OFS_EVT_SEL),
		.wr_value (pwdata[7:0]),
		.new_record (new_event),
		.sel_r    (evt_sel),
		.reject_r (evt_rej)
	);
	record_selector #(.SEL_MAX(FLT_SEL_MAX)) u_flt_sel (
		.clk      (clk),
		.rst_b    (rst_b),
		.wr_en    (wr_acc && paddr == OFS_FLT_SEL),
		.wr_value (pwdata[7:0]),
		.new_record (new_fault),
		.sel_r    (flt_sel),
		.reject_r (flt_rej)
	);
	record_selector #(.SEL_MAX(MNT_SEL_MAX)) u_mnt_sel (
		.clk      (clk),
		.rst_b    (rst_b),
		.wr_en    (wr_acc && paddr == OFS_MNT_SEL),
		.wr_value (pwdata[7:0]),
		.new_record (new_maint),
		.sel_r    (mnt_sel),
		.reject_r (mnt_rej)
	);

	// request decode
	assign page = req_r.addr[16:14];
	assign offs = req_r.addr[13:0];

	// codes 7, 8, 11 and 12 are accepted and answered with an empty result
	always_comb begin
		case (req_r.fn)
			FN_READ_COILS, FN_READ_INPUTS, FN_READ_HOLD, FN_READ_MEAS,
			FN_WRITE_ONE, FN_EXC_STATUS, FN_DIAG, FN_EVT_COUNTER,
			FN_EVT_LOG, FN_WRITE_MANY: fn_ok = 1'b1;
			default: fn_ok = 1'b0;
		endcase
	end

	// only the start address is judged; holes further on are tolerated
	always_comb begin
		case (req_r.fn)
			FN_READ_COILS:  start_ok = (page == PAGE_COIL) && offs <= PAGE_SPAN;
			FN_READ_INPUTS: start_ok = (page == PAGE_OPTO) && offs <= PAGE_SPAN;
			FN_READ_MEAS:   start_ok = (page == PAGE_MEAS) && offs <= PAGE_SPAN;
			FN_READ_HOLD, FN_WRITE_ONE, FN_WRITE_MANY:
				start_ok = (page == PAGE_SET) && offs < 14'(SET_DEPTH);
			default:        start_ok = 1'b1;
		endcase
	end

	always_comb begin
		prot_hit = 1'b0;
		for (int i = 0; i < SET_DEPTH; i++) begin
			if (protect_r[i] && 14'(i) >= offs && 14'(i) < offs + 14'(req_r.count)) begin
				prot_hit = 1'b1;
			end
		end
	end

	// request sequencer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r     <= ST_IDLE;
			ans_r       <= '0;
			idx_r       <= 8'h00;
			range_err_r <= 1'b0;
			lat_r       <= 4'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (wr_acc && paddr == OFS_CMD && pwdata[CMD_GO_BIT]) begin
						state_r     <= ST_CHECK;
						ans_r       <= '0;
						idx_r       <= 8'h00;
						range_err_r <= 1'b0;
					end
				end
				ST_CHECK: begin
					// answer priority: function, busy, address, count, protection
					state_r <= ST_DONE;
					if (!fn_ok) begin
						ans_r.exc <= EXC_FUNCTION;
					end else if (db_locked && (req_r.fn == FN_WRITE_ONE ||
						req_r.fn == FN_WRITE_MANY)) begin
						ans_r.exc <= EXC_BUSY;
					end else if (!start_ok) begin
						ans_r.exc <= EXC_ADDRESS;
					end else if (req_r.fn == FN_WRITE_MANY &&
						(req_r.count > WRITE_MANY_MAX || req_r.count == 8'h00)) begin
						ans_r.exc <= EXC_VALUE;
					end else if (prot_hit && (req_r.fn == FN_WRITE_ONE ||
						req_r.fn == FN_WRITE_MANY)) begin
						ans_r.exc <= EXC_ADDRESS;
					end else begin
						state_r <= ST_EXEC;
						lat_r   <= WRITE_LAT;
						idx_r   <= 8'(offs[3:0]);
						range_err_r <= (req_r.fn == FN_WRITE_ONE ||
							req_r.fn == FN_WRITE_MANY) && data_r > SET_LIMIT;
					end
				end
				ST_EXEC: begin
					// the settings store is slow; a go that lands meanwhile is refused
					if (lat_r != 4'h0) begin
						lat_r <= lat_r - 4'h1;
					end else begin
						state_r <= ST_DONE;
						case (req_r.fn)
							FN_READ_COILS:  ans_r.data <= contact_state;
							FN_READ_INPUTS: ans_r.data <= opto_state;
							FN_READ_MEAS:   ans_r.data <= meas_value;
							FN_READ_HOLD:   ans_r.data <= set_mem_r[idx_r[3:0]];
							default:        ans_r.data <= 16'h0000;
						endcase
						if (range_err_r) begin
							// the value is held back from the store; nothing of the request lands
							ans_r.exc <= EXC_VALUE;
						end
					end
				end
				ST_DONE: begin
					ans_r.done <= 1'b1;
					// a go already refused at its setup stays refused here
					if (wr_acc && paddr == OFS_CMD && pwdata[CMD_GO_BIT] && !pslverr) begin
						state_r     <= ST_CHECK;
						ans_r       <= '0;
						idx_r       <= 8'h00;
						range_err_r <= 1'b0;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// setting writes: a multiple write stores its one data word at the start index only
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < SET_DEPTH; i++) begin
				set_mem_r[i] <= 16'h0000;
			end
		end else if (state_r == ST_EXEC && lat_r == 4'h0 && !range_err_r &&
			(req_r.fn == FN_WRITE_ONE || req_r.fn == FN_WRITE_MANY)) begin
			set_mem_r[idx_r[3:0]] <= data_r;
		end
	end

	// configuration and request registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			req_r        <= '0;
			data_r       <= 16'h0000;
			protect_r    <= '0;
			cfg_r        <= '{BAUD_RST, SLAVE_RST, PARITY_RST, IDLE_RST, RTU_FRAMING};
			lx_r         <= '0;
			front_port_r <= 1'b0;
		end else if (wr_acc && !pslverr &&
			state_r != ST_CHECK && state_r != ST_EXEC) begin
			case (paddr)
				OFS_CMD: begin
					req_r.fn    <= pwdata[CMD_FN_LSB +: 8];
					req_r.count <= pwdata[CMD_CNT_LSB +: 8];
				end
				OFS_ADDR:      req_r.addr <= pwdata[16:0];
				OFS_DATA:      data_r <= pwdata[15:0];
				OFS_PROTECT:   protect_r <= pwdata[SET_DEPTH-1:0];
				OFS_PORT_CFG: begin
					cfg_r.baud         <= pwdata[3:0];
					cfg_r.slave_addr   <= pwdata[11:4];
					cfg_r.parity       <= pwdata[13:12];
					cfg_r.idle_timeout <= pwdata[21:14];
					// framing stays rtu whatever software writes
					cfg_r.rtu          <= RTU_FRAMING;
					front_port_r       <= pwdata[CFG_FRONT_BIT];
				end
				OFS_LOGIC_CFG: begin
					lx_r <= pwdata[17:0];
				end
				default: begin
				end
			endcase
		end
	end

	// disturbance bookkeeping
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dist_count_r <= 8'h00;
			dist_sel_r   <= 8'sh00;
		end else begin
			// saturate, so a flood of records never wraps the flag back off
			if (dist_stored && !dist_extracted && dist_count_r != 8'hff) begin
				dist_count_r <= dist_count_r + 8'h01;
			end else if (dist_extracted && !dist_stored && dist_count_r != 8'h00) begin
				dist_count_r <= dist_count_r - 8'h01;
			end
			// held signed: negative values reach records newer than the oldest unextracted
			if (wr_acc && paddr == OFS_DIST_SEL) begin
				dist_sel_r <= signed'(pwdata[7:0]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dist_flag_r    <= 1'b0;
			auto_dist_en_r <= 1'b0;
			rtu_mode_r     <= 1'b0;
		end else begin
			// one cycle behind the count, like every other status pin
			dist_flag_r    <= (dist_count_r != 8'h00);
			auto_dist_en_r <= !front_port_r;
			rtu_mode_r     <= cfg_r.rtu;
		end
	end

	// read mux
	always_comb begin
		case (paddr)
			OFS_CMD:       rdata_nxt = {24'h000000, req_r.fn};
			OFS_ADDR:      rdata_nxt = {15'h0000, req_r.addr};
			OFS_DATA:      rdata_nxt = {16'h0000, data_r};
			OFS_RESULT:    rdata_nxt = {7'h00, ans_r.done, ans_r.exc, ans_r.data};
			OFS_EVT_SEL:   rdata_nxt = {23'h000000, evt_rej, evt_sel};
			OFS_FLT_SEL:   rdata_nxt = {23'h000000, flt_rej, flt_sel};
			OFS_MNT_SEL:   rdata_nxt = {23'h000000, mnt_rej, mnt_sel};
			// the time cell of the selected disturbance rides above the selection
			OFS_DIST_SEL:  rdata_nxt = {CELL_DIST_TIME, 8'h00, dist_sel_r};
			OFS_STATUS:    rdata_nxt = {29'h0000000, db_locked,
				state_r != ST_IDLE && state_r != ST_DONE, dist_flag_r};
			OFS_PORT_CFG:  rdata_nxt = {front_port_r, 8'h00, cfg_r.rtu,
				cfg_r.idle_timeout, cfg_r.parity, cfg_r.slave_addr, cfg_r.baud};
			OFS_LOGIC_CFG: rdata_nxt = {14'h0000, lx_r};
			OFS_PROTECT:   rdata_nxt = {16'h0000, protect_r};
			// record cell base seen for the current event selection
			OFS_REC_EVENT: rdata_nxt = {CELL_EVT_FIRST, 8'h00, evt_sel};
			default:       rdata_nxt = 32'h00000000;
		endcase
	end

	// apb slave: one-cycle answer; a new command while busy is refused
	// pready comes from the setup phase, so no access ever waits
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && pwrite && paddr == OFS_CMD &&
				(state_r == ST_CHECK || state_r == ST_EXEC);
			if (psel && !penable && !pwrite) begin
				prdata <= rdata_nxt;
			end
		end
	end
endmodule : scada_record_access_slave

/* logic/record_access_pkg.sv */
package record_access_pkg;

	// apb register byte offsets
	localparam logic [7:0] OFS_CMD        = 8'h00;
	localparam logic [7:0] OFS_ADDR       = 8'h04;
	localparam logic [7:0] OFS_DATA       = 8'h08;
	localparam logic [7:0] OFS_RESULT     = 8'h0c;
	localparam logic [7:0] OFS_EVT_SEL    = 8'h10;
	localparam logic [7:0] OFS_FLT_SEL    = 8'h14;
	localparam logic [7:0] OFS_MNT_SEL    = 8'h18;
	localparam logic [7:0] OFS_DIST_SEL   = 8'h1c;
	localparam logic [7:0] OFS_STATUS     = 8'h20;
	localparam logic [7:0] OFS_PORT_CFG   = 8'h24;
	localparam logic [7:0] OFS_LOGIC_CFG  = 8'h28;
	localparam logic [7:0] OFS_PROTECT    = 8'h2c;
	localparam logic [7:0] OFS_REC_EVENT  = 8'h30;

	// record selection limits
	localparam logic [7:0] EVT_SEL_MAX  = 8'd249;
	localparam logic [7:0] EVT_COUNT    = 8'd250;
	localparam logic [7:0] FLT_SEL_MAX  = 8'd4;
	localparam logic [7:0] MNT_SEL_MAX  = 8'd4;

	// record column cells
	localparam logic [15:0] CELL_EVT_FIRST  = 16'h0102;
	localparam logic [15:0] CELL_EVT_LAST   = 16'h0105;
	localparam logic [15:0] CELL_FLT_SEL    = 16'h0105;
	localparam logic [15:0] CELL_MNT_SEL    = 16'h01f0;
	localparam logic [15:0] CELL_DIST_TIME  = 16'hb402;
	localparam logic [15:0] CELL_DIST_DATA  = 16'hb40b;
	localparam logic [15:0] CELL_LOGIC_DOM  = 16'hb204;
	localparam logic [15:0] CELL_LOGIC_GRP  = 16'hb208;
	localparam logic [15:0] CELL_LOGIC_VER  = 16'hb20c;
	localparam logic [15:0] CELL_LOGIC_MODE = 16'hb21c;
	localparam logic [15:0] CELL_LOGIC_DATA = 16'hb120;

	// function codes
	localparam logic [7:0] FN_READ_COILS   = 8'h01;
	localparam logic [7:0] FN_READ_INPUTS  = 8'h02;
	localparam logic [7:0] FN_READ_HOLD    = 8'h03;
	localparam logic [7:0] FN_READ_MEAS    = 8'h04;
	localparam logic [7:0] FN_WRITE_ONE    = 8'h06;
	localparam logic [7:0] FN_EXC_STATUS   = 8'h07;
	localparam logic [7:0] FN_DIAG         = 8'h08;
	localparam logic [7:0] FN_EVT_COUNTER  = 8'h0b;
	localparam logic [7:0] FN_EVT_LOG      = 8'h0c;
	localparam logic [7:0] FN_WRITE_MANY   = 8'h10;
	localparam logic [7:0] WRITE_MANY_MAX  = 8'd127;

	// exception codes
	localparam logic [7:0] EXC_NONE      = 8'h00;
	localparam logic [7:0] EXC_FUNCTION  = 8'h01;
	localparam logic [7:0] EXC_ADDRESS   = 8'h02;
	localparam logic [7:0] EXC_VALUE     = 8'h03;
	localparam logic [7:0] EXC_BUSY      = 8'h06;

	// address pages
	localparam logic [2:0] PAGE_COIL   = 3'd0;
	localparam logic [2:0] PAGE_OPTO   = 3'd1;
	localparam logic [2:0] PAGE_MEAS   = 3'd3;
	localparam logic [2:0] PAGE_SET    = 3'd4;
	localparam logic [13:0] PAGE_SPAN  = 14'd9999;

	// settings table
	localparam int          SET_DEPTH  = 16;
	localparam logic [15:0] SET_LIMIT  = 16'h03e8;
	localparam logic [3:0]  WRITE_LAT  = 4'd3;

	// field positions
	localparam int CMD_FN_LSB    = 0;
	localparam int CMD_CNT_LSB   = 8;
	localparam int CMD_GO_BIT    = 31;
	localparam int STAT_DIST_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_LOCK_BIT = 2;
	localparam int CFG_FRONT_BIT = 31;

	// reset values of the serial port settings
	localparam logic [3:0]  BAUD_RST    = 4'h2;
	localparam logic [7:0]  SLAVE_RST   = 8'h01;
	localparam logic [1:0]  PARITY_RST  = 2'h0;
	localparam logic [7:0]  IDLE_RST    = 8'h0f;
	localparam logic        RTU_FRAMING = 1'b1;

	typedef struct packed {
		logic [3:0] baud;
		logic [7:0] slave_addr;
		logic [1:0] parity;
		logic [7:0] idle_timeout;
		logic       rtu;
	} port_cfg_t;

	typedef struct packed {
		logic [7:0]  fn;
		logic [7:0]  count;
		logic [16:0] addr;
	} request_t;

	typedef struct packed {
		logic [7:0]  exc;
		logic [15:0] data;
		logic        done;
	} answer_t;

	typedef struct packed {
		logic [1:0] domain;
		logic [3:0] group;
		logic [7:0] version;
		logic [3:0] mode;
	} logic_xfer_t;

endpackage : record_access_pkg

/* logic/record_selector.sv */
`timescale 1ns/100ps
module record_selector
	import record_access_pkg::*;
#(
	parameter logic [7:0] SEL_MAX = 8'd4
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_value,
	input  wire logic       new_record,
	output logic [7:0]      sel_r,
	output logic            reject_r
);
	// out-of-range writes keep the earlier selection
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sel_r    <= 8'h00;
			reject_r <= 1'b0;
		end else if (wr_en) begin
			reject_r <= (wr_value > SEL_MAX);
			if (wr_value <= SEL_MAX) begin
				sel_r <= wr_value;
			end
		end else if (new_record && sel_r < SEL_MAX) begin
			// index counts from newest, so the held record moves one back
			sel_r <= sel_r + 8'h01;
		end
	end
endmodule : record_selector

/* verification/record_access_asserts.sv */
`timescale 1ns/100ps
module record_access_asserts
	import record_access_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        dist_stored,
	input wire logic        dist_extracted,
	input wire logic        dist_flag_r,
	input wire logic        auto_dist_en_r,
	input wire logic        rtu_mode_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	err_on_cmd_a: assert property (pslverr |-> pready && pwrite && paddr == OFS_CMD)
		else $error("pslverr outside command write");
	framing_fixed_a: assert property ($past(rst_b) && $past(rst_b, 2) |-> rtu_mode_r)
		else $error("rtu mode dropped");
	dist_flag_set_a: assert property (dist_stored && !dist_extracted |-> ##2 dist_flag_r)
		else $error("disturbance flag not raised");
	dist_flag_src_a: assert property ($rose(dist_flag_r) |-> $past(dist_stored, 2))
		else $error("disturbance flag without record");
	front_port_a: assert property (pready && pwrite && paddr == OFS_PORT_CFG
		|-> ##2 auto_dist_en_r != $past(pwdata[CFG_FRONT_BIT], 2))
		else $error("auto extraction enable wrong");
	unmapped_read_a: assert property (pready && !pwrite && paddr == 8'h40 |-> prdata == 32'h0)
		else $error("unmapped read not zero");

	cover property (pslverr);
	cover property ($rose(dist_flag_r));
	cover property (pready && pwrite && paddr == OFS_CMD);
endmodule : record_access_asserts

bind scada_record_access_slave record_access_asserts record_access_asserts_i (
	.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .dist_stored, .dist_extracted, .dist_flag_r, .auto_dist_en_r, .rtu_mode_r
);

/* verification/field_side.sv */
`timescale 1ns/100ps
module field_side (
	input  wire logic clk,
	output logic       new_event,
	output logic       new_fault,
	output logic       new_maint,
	output logic       dist_stored,
	output logic       dist_extracted,
	output logic       db_locked,
	output logic [15:0] contact_state,
	output logic [15:0] opto_state,
	output logic [15:0] meas_value
);
	logic [4:0] pul;

	initial begin
		pul = 5'h0;
		db_locked = 1'b0;
	end
	assign {dist_extracted, dist_stored, new_maint, new_fault, new_event} = pul;
	// distinct levels so a wrong page shows up as a wrong value
	assign contact_state = 16'h00a5;
	assign opto_state = 16'h0c3c;
	assign meas_value = 16'h7e01;

	// one-cycle record pulse: 0 event, 1 fault, 2 maint, 3 dist in, 4 dist out
	task fire(input int k);
		pul[k] <= 1'b1;
		@(posedge clk);
		pul[k] <= 1'b0;
		@(posedge clk);
	endtask : fire

	task lock(input logic v);
		db_locked <= v;
		@(posedge clk);
	endtask : lock
endmodule : field_side

/* verification/scada_record_access_slave_bench.sv */
`timescale 1ns/100ps
module scada_record_access_slave_bench;
	import record_access_pkg::*;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, res;
	logic        ne, nf, nm, ds, dx, lk, dflag, auto_en, rtu;
	logic [15:0] cs, os, mv;
	int          n_fail, samples_checked;
	logic [7:0]  sel_ofs [3] = '{OFS_EVT_SEL, OFS_FLT_SEL, OFS_MNT_SEL};
	logic [7:0]  sel_max [3] = '{EVT_SEL_MAX, FLT_SEL_MAX, MNT_SEL_MAX};
	logic [7:0]  bad_fn [5] = '{8'h00, 8'h05, 8'h09, 8'h11, 8'hff};
	logic [7:0]  ok_fn [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08,
		8'h0b, 8'h0c, 8'h10};

	scada_record_access_slave scada_record_access_slave_i (.clk, .rst_b, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .new_event(ne),
		.new_fault(nf), .new_maint(nm), .dist_stored(ds), .dist_extracted(dx),
		.db_locked(lk), .contact_state(cs), .opto_state(os), .meas_value(mv),
		.dist_flag_r(dflag), .auto_dist_en_r(auto_en), .rtu_mode_r(rtu));
	field_side field_side_i (.clk, .new_event(ne), .new_fault(nf), .new_maint(nm),
		.dist_stored(ds), .dist_extracted(dx), .db_locked(lk), .contact_state(cs),
		.opto_state(os), .meas_value(mv));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task end_of_test;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	// one transfer, then an idle cycle so no signal is driven twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task poll;
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_RESULT, 32'h0);
			n++;
		end while (q[24] !== 1'b1 && n < 40);
		if (q[24] !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
		res = q;
	endtask : poll

	task cmd(input logic [7:0] fn, input logic [7:0] cnt, input logic [16:0] a,
		input logic [15:0] d);
		apb(1'b1, OFS_ADDR, {15'h0, a});
		apb(1'b1, OFS_DATA, {16'h0, d});
		apb(1'b1, OFS_CMD, {1'b1, 15'h0, cnt, fn});
		poll();
	endtask : cmd

	initial begin
		{psel, penable, pwrite, paddr, pwdata, n_fail, samples_checked} = '0;
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk(rtu, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[2:0], 3'h0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, sel_ofs[i], {24'h0, sel_max[i]});
			apb(1'b0, sel_ofs[i], 32'h0);
			chk(q[8:0], {1'b0, sel_max[i]});
			apb(1'b1, sel_ofs[i], {24'h0, sel_max[i] + 8'd1});
			apb(1'b0, sel_ofs[i], 32'h0);
			chk(q[8:0], {1'b1, sel_max[i]});
			apb(1'b1, sel_ofs[i], 32'h0);
			field_side_i.fire(i);
			apb(1'b0, sel_ofs[i], 32'h0);
			chk(q[7:0], 8'h01);
		end
		apb(1'b0, OFS_REC_EVENT, 32'h0);
		chk(q, {CELL_EVT_FIRST, 16'h0001});
		apb(1'b1, OFS_PORT_CFG, 32'h8003_55a3);
		repeat (2) @(posedge clk);
		chk(auto_en, 1'b0);
		apb(1'b0, OFS_PORT_CFG, 32'h0);
		chk(q, 32'h8043_55a3);
		apb(1'b1, OFS_PORT_CFG, 32'h0003_55a3);
		repeat (2) @(posedge clk);
		chk(auto_en, 1'b1);
		field_side_i.fire(3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({dflag, q[STAT_DIST_BIT]}, 2'b11);
		field_side_i.fire(4);
		repeat (2) @(posedge clk);
		chk(dflag, 1'b0);
		apb(1'b1, OFS_DIST_SEL, 32'h0000_00ff);
		apb(1'b0, OFS_DIST_SEL, 32'h0);
		chk(q, {CELL_DIST_TIME, 16'h00ff});
		apb(1'b1, OFS_LOGIC_CFG, 32'h0002_a5c3);
		apb(1'b0, OFS_LOGIC_CFG, 32'h0);
		chk(q, 32'h0002_a5c3);
		foreach (bad_fn[i]) begin
			cmd(bad_fn[i], 8'd1, 17'h10000, 16'h0);
			chk(res[23:16], EXC_FUNCTION);
		end
		foreach (ok_fn[i]) begin
			cmd(ok_fn[i], 8'd1, 17'h10000, 16'h0);
			chk(res[23:16] == EXC_FUNCTION, 1'b0);
		end
		cmd(FN_WRITE_ONE, 8'd1, 17'h10002, 16'h0123);
		cmd(FN_READ_HOLD, 8'd1, 17'h10002, 16'h0);
		chk(res[23:0], 24'h000123);
		cmd(FN_READ_COILS, 8'd1, 17'h00000, 16'h0);
		chk(res[23:0], {8'h0, cs});
		cmd(FN_READ_INPUTS, 8'd1, 17'h04000, 16'h0);
		chk(res[23:0], {8'h0, os});
		cmd(FN_READ_MEAS, 8'd1, 17'h0c000, 16'h0);
		chk(res[23:0], {8'h0, mv});
		cmd(FN_READ_HOLD, 8'd1, 17'h10010, 16'h0);
		chk(res[23:16], EXC_ADDRESS);
		cmd(FN_WRITE_MANY, 8'd4, 17'h1000f, 16'h0005);
		chk(res[23:16], EXC_NONE);
		cmd(FN_WRITE_ONE, 8'd1, 17'h10003, 16'd1001);
		chk(res[23:16], EXC_VALUE);
		cmd(FN_WRITE_MANY, 8'd128, 17'h10000, 16'h0001);
		chk(res[23:16], EXC_VALUE);
		cmd(FN_WRITE_MANY, WRITE_MANY_MAX, 17'h10000, 16'h0001);
		chk(res[23:16], EXC_NONE);
		apb(1'b1, OFS_PROTECT, 32'h0000_0020);
		cmd(FN_WRITE_MANY, 8'd2, 17'h10004, 16'h0007);
		chk(res[23:16], EXC_ADDRESS);
		cmd(FN_READ_HOLD, 8'd1, 17'h10004, 16'h0);
		chk(res[23:0], 24'h0);
		field_side_i.lock(1'b1);
		cmd(FN_WRITE_ONE, 8'd1, 17'h10001, 16'h0002);
		chk(res[23:16], EXC_BUSY);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[STAT_LOCK_BIT], 1'b1);
		field_side_i.lock(1'b0);
		apb(1'b1, OFS_CMD, {1'b1, 15'h0, 8'd1, FN_READ_HOLD});
		apb(1'b1, OFS_CMD, {1'b1, 15'h0, 8'd1, FN_READ_HOLD});
		chk(e, 1'b1);
		poll();
		apb(1'b1, 8'h40, 32'h1234_5678);
		apb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		end_of_test();
	end
endmodule : scada_record_access_slave_bench
